// ==== hw/tsr_bridge.sv ====
// The APB slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tsr_bridge
  import tsr_pkg::*;
(
  // clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output var  logic [31:0]                   prdata,
  output var  logic                          pready,
  output var  logic                          pslverr,
  // chassis strap: high for the three-segment backplane
  input  wire logic                          three_seg_strap,
  // backplane trigger lines, per segment
  input  wire logic [NSEGS-1:0][NLINES-1:0]  trig_in,
  output var  logic [NSEGS-1:0][NLINES-1:0]  trig_out,
  output var  logic [NSEGS-1:0][NLINES-1:0]  trig_oe
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [NSEGS-1:0][NLINES-1:0] trig_s1_q;
  logic [NSEGS-1:0][NLINES-1:0] trig_s2_q;
  logic                         strap_s1_q;
  logic                         strap_s2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_s1_q <= '0;
      trig_s2_q <= '0;
    end else begin
      trig_s1_q <= trig_in;
      trig_s2_q <= trig_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end else begin
      strap_s1_q <= three_seg_strap;
      strap_s2_q <= strap_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // backplane size capture
  // ----------------------------------------------------------------
  // the strap is caught once after release; routes are refused until then,
  // so the segment count can never change under an active route
  tsr_state_t st_q;
  logic [1:0] lock_cnt_q;
  logic       three_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q       <= ST_CAPT;
      lock_cnt_q <= 2'h0;
      three_q    <= 1'b0;
    end else begin
      case (st_q)
        ST_CAPT: begin
          if (lock_cnt_q == LOCK_CYCLES) begin
            three_q <= strap_s2_q;
            st_q    <= ST_RUN;
          end else begin
            lock_cnt_q <= lock_cnt_q + 2'h1;
          end
        end
        ST_RUN: begin
          st_q <= ST_RUN;
        end
        default: begin
          st_q <= ST_CAPT;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic        setup;
  logic        access;
  logic        addr_hit;
  logic        wr_bad;
  logic        route_ok;
  logic [31:0] rd_val;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  // configuration state, read by the decode and written further down
  logic [31:0] route_q;
  logic        rej_q;
  logic [4:0]  slot_q;

  assign setup    = psel & ~penable;
  assign access   = psel & penable & pready_q;
  assign route_ok = tsr_word_ok(pwdata, three_q) & (st_q == ST_RUN);

  always_comb begin
    addr_hit = 1'b1;
    wr_bad   = 1'b0;
    rd_val   = 32'h0000_0000;
    case (paddr)
      ADDR_ROUTE: begin
        rd_val = route_q;
        wr_bad = pwrite & ~route_ok;
      end
      ADDR_STATUS: begin
        rd_val[ST_THREE_BIT] = three_q;
        rd_val[ST_REJ_BIT]   = rej_q;
      end
      ADDR_LEVEL: begin
        rd_val[NLINES*NSEGS-1:0] = trig_s2_q;
      end
      ADDR_SLOTQ: begin
        rd_val[4:0]                           = slot_q;
        rd_val[SLOTQ_SEG_LO +: 2]             = tsr_seg_of_slot(slot_q, three_q);
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // answer comes in the first access cycle: pready is registered from setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      if (setup) begin
        pslverr_q <= ~addr_hit | wr_bad;
        prdata_q  <= (pwrite || !addr_hit) ? 32'h0000_0000 : rd_val;
      end
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic        wr_route;
  logic        wr_reject;

  assign wr_route  = access & pwrite & (paddr == ADDR_ROUTE) & ~pslverr_q;
  assign wr_reject = access & pwrite & (paddr == ADDR_ROUTE) & pslverr_q;

  // volatile routes: reset or an accepted write of zero clears them, no copy survives a restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_q <= ROUTE_RST;
    end else if (wr_route) begin
      route_q <= pwdata;
    end
  end

  // sticky refusal flag; a new refusal beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rej_q <= 1'b0;
    end else if (wr_reject) begin
      rej_q <= 1'b1;
    end else if (access && pwrite && paddr == ADDR_STATUS && pwdata[ST_REJ_BIT]) begin
      rej_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_q <= SLOT_RST;
    end else if (access && pwrite && paddr == ADDR_SLOTQ) begin
      slot_q <= pwdata[4:0];
    end
  end

  // ----------------------------------------------------------------
  // per-line repeaters
  // ----------------------------------------------------------------
  // each line has its own relay, so no route on one line touches another
  for (genvar l = 0; l < NLINES; l++) begin : g_line
    tsr_line_if lif ();

    assign lif.en    = route_q[l*NDIR +: NDIR];
    assign lif.three = three_q;
    for (genvar s = 0; s < NSEGS; s++) begin : g_seg
      assign lif.lvl[s]   = trig_s2_q[s][l];
      assign trig_out[s][l] = lif.drv[s];
      assign trig_oe[s][l]  = lif.oe[s];
    end

    tsr_line_relay u_relay (
      .pclk    (pclk),
      .presetn (presetn),
      .lif     (lif.relay)
    );
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // per-direction views of the route word, one bit per line
  logic [NLINES-1:0] en12_v;
  logic [NLINES-1:0] en21_v;
  logic [NLINES-1:0] en23_v;
  logic [NLINES-1:0] en32_v;

  always_comb begin
    en12_v = '0;
    en21_v = '0;
    en23_v = '0;
    en32_v = '0;
    for (int l = 0; l < NLINES; l++) begin
      en12_v[l] = route_q[l*NDIR + DIR_12];
      en21_v[l] = route_q[l*NDIR + DIR_21];
      en23_v[l] = route_q[l*NDIR + DIR_23];
      en32_v[l] = route_q[l*NDIR + DIR_32];
    end
  end

  reset_iso_a: assert property (@(posedge pclk)
    !$past(presetn) |-> (route_q == ROUTE_RST) ##1 (trig_oe == '0))
    else $error("segments not isolated after reset");

  reset_lose_a: assert property (@(posedge pclk)
    !presetn |=> (route_q == ROUTE_RST))
    else $error("route survived reset");

  reject_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_reject |=> $stable(route_q) && rej_q)
    else $error("refused route write changed the routes");

  accept_valid_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && pwrite && paddr == ADDR_ROUTE && st_q == ST_RUN && three_q
     && tsr_word_ok(pwdata, 1'b1)) ##1 access |=> (route_q == $past(pwdata)))
    else $error("valid route combination refused");

  legal_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    tsr_word_ok(route_q, three_q))
    else $error("illegal route combination stored");

  two_seg_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_RUN && !three_q) |-> (trig_oe[2] == '0))
    else $error("third segment driven on ten-slot backplane");

  slot_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    (three_q && slot_q == 5'h07) |-> (tsr_seg_of_slot(slot_q, three_q) == 2'h2))
    else $error("slot seven not in segment two");

  level_visible_a: assert property (@(posedge pclk) disable iff (!presetn)
    (route_q[DIR_12] && $stable(route_q[DIR_12]) && $stable(trig_s2_q[0][0]))
    |=> trig_out[1][0] == $past(trig_s2_q[0][0]))
    else $error("line zero not copied from segment one");

  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready)
    else $error("apb answer not in first access cycle");

  // output enables lag the route word by exactly one edge
  oe_seg1_a: assert property (@(posedge pclk) disable iff (!presetn)
    trig_oe[0] == $past(en21_v))
    else $error("segment one enables do not follow the routes");

  oe_seg2_a: assert property (@(posedge pclk) disable iff (!presetn)
    trig_oe[1] == $past(en12_v | en32_v))
    else $error("segment two enables do not follow the routes");

  oe_seg3_a: assert property (@(posedge pclk) disable iff (!presetn)
    trig_oe[2] == $past(en23_v & {NLINES{three_q}}))
    else $error("segment three enables do not follow the routes");

  out_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (trig_out & ~trig_oe) == '0)
    else $error("line value driven while bridge output disabled");

  iso_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (route_q == ROUTE_RST) |=> (trig_oe == '0))
    else $error("segment driven with no route enabled");

  bidir_12_a: assert property (@(posedge pclk) disable iff (!presetn)
    (en12_v & en21_v) == '0)
    else $error("both directions stored on boundary one-two");

  bidir_23_a: assert property (@(posedge pclk) disable iff (!presetn)
    (en23_v & en32_v) == '0)
    else $error("both directions stored on boundary two-three");

  double_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
    (en12_v & en32_v) == '0)
    else $error("segment two fed from both sides");

  two_seg_route_a: assert property (@(posedge pclk) disable iff (!presetn)
    !three_q |-> ((en23_v | en32_v) == '0))
    else $error("boundary two-three used on ten-slot backplane");

  strap_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_RUN) |=> $stable(three_q))
    else $error("segment count changed after capture");

  early_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && pwrite && paddr == ADDR_ROUTE && st_q != ST_RUN) |=> pslverr)
    else $error("route write before strap capture not refused");

  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !addr_hit) |=> pslverr)
    else $error("unmapped access not flagged");

  route_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_route |=> $stable(route_q))
    else $error("routes changed without an accepted write");

  rej_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == ADDR_STATUS && pwdata[ST_REJ_BIT] && !wr_reject)
    |=> !rej_q)
    else $error("refusal flag not cleared");

  // seg1 fed from seg2 only when seg2 is not itself fed from seg3
  copy_seg2_a: assert property (@(posedge pclk) disable iff (!presetn)
    (en21_v[0] && !en32_v[0]) |=> trig_out[0][0] == $past(trig_s2_q[1][0]))
    else $error("line zero not copied from segment two");

  chain_seg3_a: assert property (@(posedge pclk) disable iff (!presetn)
    (en12_v[0] && en23_v[0] && three_q) |=> trig_out[2][0] == $past(trig_s2_q[0][0]))
    else $error("chained route does not carry segment one level");

  level_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == ADDR_LEVEL) |=> prdata[23:0] == $past(trig_s2_q))
    else $error("level register does not show synced lines");

endmodule
`default_nettype wire

// ==== hw/tsr_line_relay.sv ====
`timescale 1ns/1ps
`default_nettype none
module tsr_line_relay
  import tsr_pkg::*;
(
  // clock and reset
  input wire logic    pclk,
  input wire logic    presetn,
  // one trigger line
  tsr_line_if.relay   lif
);

  logic [NSEGS-1:0] drv_q;
  logic [NSEGS-1:0] oe_q;
  logic             lvl2_eff;

  // level seen in segment two, taken at its source to avoid stacking pin latency
  always_comb begin
    if (lif.en[DIR_12])      lvl2_eff = lif.lvl[0];
    else if (lif.en[DIR_32]) lvl2_eff = lif.lvl[2];
    else                     lvl2_eff = lif.lvl[1];
  end

  // one repeater per boundary direction, each to an adjacent segment only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_q  <= 3'h0;
      drv_q <= 3'h0;
    end else begin
      oe_q[0]  <= lif.en[DIR_21];
      oe_q[1]  <= lif.en[DIR_12] | lif.en[DIR_32];
      oe_q[2]  <= lif.en[DIR_23] & lif.three;
      drv_q[0] <= lif.en[DIR_21] & lvl2_eff;
      drv_q[1] <= lif.en[DIR_12] ? lif.lvl[0] : (lif.en[DIR_32] & lif.lvl[2]);
      drv_q[2] <= lif.en[DIR_23] & lif.three & lvl2_eff;
    end
  end

  assign lif.drv = drv_q;
  assign lif.oe  = oe_q;

  no_bidir_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(lif.en[DIR_12] && lif.en[DIR_21]) && !(lif.en[DIR_23] && lif.en[DIR_32]))
    else $error("both directions enabled on one boundary");

  single_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(lif.en[DIR_12] && lif.en[DIR_32]))
    else $error("segments one and three both drive segment two");

  copy_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    lif.en[DIR_12] |=> (drv_q[1] == $past(lif.lvl[0])))
    else $error("segment two does not follow segment one");

  drive_dest_a: assert property (@(posedge pclk) disable iff (!presetn)
    lif.en[DIR_21] |=> oe_q[0])
    else $error("destination not driven while route active");

endmodule
`default_nettype wire

// ==== shared/tsr_line_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface tsr_line_if;
  import tsr_pkg::*;
  logic [NDIR-1:0]  en;
  logic [NSEGS-1:0] lvl;
  logic             three;
  logic [NSEGS-1:0] drv;
  logic [NSEGS-1:0] oe;
  modport ctrl  (output en, output lvl, output three, input drv, input oe);
  modport relay (input en, input lvl, input three, output drv, output oe);
endinterface
`default_nettype wire

// ==== shared/tsr_pkg.sv ====
package tsr_pkg;

  localparam int unsigned NLINES = 8;
  localparam int unsigned NSEGS  = 3;
  localparam int unsigned NDIR   = 4;

  // direction enable bits inside one line's nibble
  localparam int unsigned DIR_12 = 0;
  localparam int unsigned DIR_21 = 1;
  localparam int unsigned DIR_23 = 2;
  localparam int unsigned DIR_32 = 3;

  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_ROUTE  = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LEVEL  = 8'h08;
  localparam logic [7:0] ADDR_SLOTQ  = 8'h0c;

  // field positions
  localparam int unsigned ST_THREE_BIT = 0;
  localparam int unsigned ST_REJ_BIT   = 1;
  localparam int unsigned SLOTQ_SEG_LO = 8;

  // reset values and counts
  localparam logic [31:0] ROUTE_RST   = 32'h0000_0000;
  localparam logic [4:0]  SLOT_RST    = 5'h00;
  localparam logic [1:0]  LOCK_CYCLES = 2'h2;

  // slot boundaries
  localparam logic [4:0] SEG1_LAST3 = 5'h06;
  localparam logic [4:0] SEG2_LAST3 = 5'h0c;
  localparam logic [4:0] SLOT_MAX3  = 5'h12;
  localparam logic [4:0] SEG1_LAST2 = 5'h05;
  localparam logic [4:0] SLOT_MAX2  = 5'h0a;

  typedef enum logic [1:0] {
    ST_CAPT = 2'b01,
    ST_RUN  = 2'b10
  } tsr_state_t;

  // legal direction set for one line
  function automatic logic tsr_nib_ok(input logic [3:0] n, input logic three);
    logic ok;
    ok = 1'b1;
    if (n[DIR_12] && n[DIR_21]) ok = 1'b0;
    if (n[DIR_23] && n[DIR_32]) ok = 1'b0;
    if (n[DIR_12] && n[DIR_32]) ok = 1'b0;
    if (!three && (n[DIR_23] || n[DIR_32])) ok = 1'b0;
    return ok;
  endfunction

  function automatic logic tsr_word_ok(input logic [31:0] w, input logic three);
    logic ok;
    ok = 1'b1;
    for (int l = 0; l < NLINES; l++) begin
      ok = ok & tsr_nib_ok(w[l*NDIR +: NDIR], three);
    end
    return ok;
  endfunction

  // 0 = no such slot, else segment number
  function automatic logic [1:0] tsr_seg_of_slot(input logic [4:0] s, input logic three);
    logic [1:0] seg;
    seg = 2'h0;
    if (three) begin
      if (s >= 5'h01 && s <= SEG1_LAST3) seg = 2'h1;
      else if (s > SEG1_LAST3 && s <= SEG2_LAST3) seg = 2'h2;
      else if (s > SEG2_LAST3 && s <= SLOT_MAX3) seg = 2'h3;
    end else begin
      if (s >= 5'h01 && s <= SEG1_LAST2) seg = 2'h1;
      else if (s > SEG1_LAST2 && s <= SLOT_MAX2) seg = 2'h2;
    end
    return seg;
  endfunction

endpackage

// ==== test/trigger_segment_router_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module trigger_segment_router_tb;
  import tsr_pkg::*;
  logic                          pclk;
  logic                          presetn;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  logic [7:0]                    paddr;
  logic [31:0]                   pwdata;
  logic [31:0]                   prdata;
  logic                          pready;
  logic                          pslverr;
  logic                          strap;
  logic [NSEGS-1:0][NLINES-1:0]  trig_in;
  logic [NSEGS-1:0][NLINES-1:0]  trig_out;
  logic [NSEGS-1:0][NLINES-1:0]  trig_oe;
  logic [NSEGS-1:0][NLINES-1:0]  lv;
  logic [31:0]                   rd_v;
  logic                          er_v;
  logic [31:0]                   cur;
  int                            seed;
  int                            err_total;
  int                            n_compared;
  localparam logic [3:0] LEGAL [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'ha, 4'h6};

  tsr_bridge DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .three_seg_strap(strap), .trig_in(trig_in), .trig_out(trig_out),
    .trig_oe(trig_oe));
  tsr_module_model modules (.bridge_out(trig_out), .bridge_oe(trig_oe), .mod_lvl(lv),
    .line_lvl(trig_in));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic logic [47:0] expect_drive(input logic [31:0] r, input logic [23:0] m);
    logic [23:0] oe;
    logic [23:0] v;
    logic [3:0]  n;
    logic        s2;
    for (int l = 0; l < 8; l++) begin
      n = r[4*l +: 4];
      s2 = n[0] ? m[l] : (n[3] ? m[16+l] : m[8+l]);
      oe[l] = n[1];
      oe[8+l] = n[0] | n[3];
      oe[16+l] = n[2];
      v[l] = n[1] & s2;
      v[8+l] = n[0] ? m[l] : (n[3] & m[16+l]);
      v[16+l] = n[2] & s2;
    end
    return {oe, v};
  endfunction

  function automatic logic legal(input logic [3:0] n, input logic t);
    if (t) return n inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'ha, 4'h6};
    return n inside {4'h0, 4'h1, 4'h2};
  endfunction

  function automatic logic [1:0] seg_of(input int s, input logic t);
    if (t) return (s >= 1 && s <= 6) ? 2'h1 : (s >= 7 && s <= 12) ? 2'h2 :
                  (s >= 13 && s <= 18) ? 2'h3 : 2'h0;
    return (s >= 1 && s <= 5) ? 2'h1 : (s >= 6 && s <= 10) ? 2'h2 : 2'h0;
  endfunction

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    chk("pslverr", e, er_v);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rd_v);
  endtask

  // fresh random module levels, then the relayed result at the pins
  task automatic pins(input logic [31:0] r);
    logic [47:0] x;
    @(posedge pclk);
    lv <= 24'($random(seed));
    repeat (6) @(posedge pclk);
    x = expect_drive(r, lv);
    chk("trig", x, {trig_oe, trig_out});
    rreg(ADDR_LEVEL, {8'h00, (x[47:24] & x[23:0]) | (~x[47:24] & lv)});
  endtask

  task automatic reset_dut();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic nibs(input logic t);
    logic [31:0] w;
    int          l;
    cur = 32'h0;
    for (int n = 0; n < 16; n++) begin
      l = $random(seed) & 7;
      w = cur;
      w[4*l +: 4] = 4'(n);
      wreg(ADDR_ROUTE, w, !legal(4'(n), t));
      if (legal(4'(n), t)) cur = w;
      rreg(ADDR_ROUTE, cur);
      if (!legal(4'(n), t)) begin
        rreg(ADDR_STATUS, {30'h0, 1'b1, t});
        wreg(ADDR_STATUS, 32'h2, 1'b0);
      end
    end
    pins(cur);
  endtask

  task automatic slots(input logic t);
    for (int s = 0; s < 32; s++) begin
      wreg(ADDR_SLOTQ, 32'(s), 1'b0);
      rreg(ADDR_SLOTQ, {22'h0, seg_of(s, t), 3'h0, 5'(s)});
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    conclude();
  end

  initial begin
    seed = 32'h7dc4014b;
    err_total = 0;
    n_compared = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    strap = 1'b1;
    lv = '0;
    reset_dut();
    // a route write before the strap is captured must bounce
    wreg(ADDR_ROUTE, 32'h1, 1'b1);
    rreg(ADDR_ROUTE, ROUTE_RST);
    pins(32'h0);
    rreg(ADDR_STATUS, 32'h3);
    wreg(ADDR_STATUS, 32'h2, 1'b0);
    rreg(ADDR_STATUS, 32'h1);
    wreg(8'h10, 32'h0, 1'b1);
    for (int it = 0; it < 16; it++) begin
      for (int l = 0; l < 8; l++) begin
        cur[4*l +: 4] = (it < 8) ? LEGAL[(l + it) % 8] : LEGAL[$random(seed) & 7];
      end
      wreg(ADDR_ROUTE, cur, 1'b0);
      rreg(ADDR_ROUTE, cur);
      pins(cur);
      pins(cur);
    end
    nibs(1'b1);
    reset_dut();
    chk("trig_oe", 48'h0, trig_oe);
    rreg(ADDR_ROUTE, ROUTE_RST);
    // host restores its saved routes after the restart
    wreg(ADDR_ROUTE, cur, 1'b0);
    pins(cur);
    slots(1'b1);
    @(posedge pclk);
    strap <= 1'b0;
    reset_dut();
    repeat (4) @(posedge pclk);
    rreg(ADDR_STATUS, 32'h0);
    nibs(1'b0);
    slots(1'b0);
    conclude();
  end
endmodule
`default_nettype wire

// ==== test/tsr_module_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tsr_module_model
  import tsr_pkg::*;
(
  // bridge side of each segment line
  input  wire logic [NSEGS-1:0][NLINES-1:0] bridge_out,
  input  wire logic [NSEGS-1:0][NLINES-1:0] bridge_oe,
  // levels the slot modules want to drive
  input  wire logic [NSEGS-1:0][NLINES-1:0] mod_lvl,
  // resolved backplane level per segment line
  output var  logic [NSEGS-1:0][NLINES-1:0] line_lvl
);
  // modules keep off any line the bridge drives into their segment
  assign line_lvl = (bridge_oe & bridge_out) | (~bridge_oe & mod_lvl);
endmodule
`default_nettype wire
